/* File: inc/lutac_pkg.sv */
package lutac_pkg;
	localparam logic [15:0] OFF_INDEX0 = 16'h0410;
	localparam logic [15:0] OFF_INDEX1 = 16'h0414;
	localparam logic [15:0] OFF_LOOKUP_CTRL = 16'h0418;
	localparam logic [15:0] OFF_STATIC_CTRL = 16'h041c;
	localparam logic [15:0] OFF_ENTRY1 = 16'h0420;
	localparam logic [15:0] OFF_ENTRY2 = 16'h0424;
	localparam logic [15:0] OFF_ENTRY3 = 16'h0428;
	localparam logic [15:0] OFF_ENTRY4 = 16'h042c;
	localparam int GO_BIT = 7;
	localparam int READY_BIT = 6;
	localparam int EITHER_BIT = 5;
	localparam int DIRECT_BIT = 2;
	localparam int RES_LSB = 3;
	localparam int ACT_LSB = 0;
	localparam int COUNT_LSB = 16;
	localparam int SEL_BIT = 1;
	localparam int SOP_BIT = 0;
	localparam int SRES_LSB = 2;
	localparam int SIDX_LSB = 16;
	localparam int FID_LSB = 16;
	localparam int CLEAR_LANE = 3;
	localparam logic [31:0] INDEX0_WMASK = 32'h807f_ffff;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [11:0] RST_ADDR = 12'h000;
	localparam logic [13:0] RST_COUNT = 14'h0000;

	typedef enum logic [1:0] {ACT_NOP = 2'h0, ACT_WRITE = 2'h1, ACT_READ = 2'h2, ACT_SEARCH = 2'h3} lutac_action_e;
	typedef enum logic [1:0] {TBL_LOOKUP = 2'h0, TBL_STATIC = 2'h1, TBL_RMC = 2'h2} lutac_table_e;
	typedef enum logic [4:0] {
		FSM_IDLE = 5'h01,
		FSM_LK = 5'h02,
		FSM_SCAN = 5'h04,
		FSM_HOLD = 5'h08,
		FSM_ST = 5'h10
	} lutac_fsm_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} lutac_reg_req_s;

	typedef struct packed {
		lutac_table_e sel;
		logic write;
		logic direct;
		logic [11:0] addr;
		logic [6:0] filter_group_id;
		logic [47:0] mac;
		logic [3:0][31:0] wdata;
	} lutac_tbl_cmd_s;

	typedef struct packed {
		logic ack;
		logic hit;
		logic [3:0][31:0] rdata;
	} lutac_tbl_rsp_s;

	typedef struct packed {
		logic busy;
		logic done;
		logic hit;
		lutac_tbl_cmd_s cmd;
		logic [3:0][31:0] rdata;
	} lutac_port_s;

	typedef struct packed {
		lutac_fsm_e fsm;
		logic [31:0] idx0;
		logic [31:0] idx1;
		logic lk_go;
		logic lk_ready;
		logic srch_seen;
		logic [1:0] lk_res;
		logic lk_direct;
		lutac_action_e lk_act;
		logic [13:0] lk_count;
		logic [11:0] scan;
		logic [5:0] st_idx;
		logic st_go;
		logic [4:0] st_res;
		logic st_sel;
		logic st_read;
		logic [3:0][31:0] entry;
		logic [31:0] rdata;
		logic rvalid;
	} lutac_main_s;
endpackage

/* File: hdl/lutac_tbl_port.sv */
`timescale 1ns/100ps
`default_nettype none
module lutac_tbl_port
	import lutac_pkg::*;
(
	input wire logic i_clock, // core clock
	input wire logic i_sys_rst, // async reset, high
	input wire logic i_start, // launch one table access
	input wire lutac_tbl_cmd_s i_cmd, // access to launch
	input wire lutac_tbl_rsp_s i_rsp, // table answer
	output logic o_req, // access outstanding
	output lutac_tbl_cmd_s o_cmd, // held access
	output logic o_done, // answer taken, one cycle
	output logic o_hit, // entry valid on answer
	output logic [3:0][31:0] o_rdata // captured entry words
);
	lutac_port_s q;
	lutac_port_s d;

	always_comb
	begin
		d = q;
		d.done = 1'b0;
		if (!q.busy && i_start)
		begin
			d.busy = 1'b1;
			d.cmd = i_cmd;
		end
		if (q.busy && i_rsp.ack)
		begin
			d.busy = 1'b0;
			d.done = 1'b1;
			d.hit = i_rsp.hit;
			d.rdata = i_rsp.rdata;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign o_req = q.busy;
	assign o_cmd = q.cmd;
	assign o_done = q.done;
	assign o_hit = q.hit;
	assign o_rdata = q.rdata;
endmodule
`default_nettype wire

/* File: hdl/lutac_top.sv */
`timescale 1ns/100ps
`default_nettype none
module lutac_top
	import lutac_pkg::*;
#(
	parameter int LOOKUP_DEPTH = 4096
)
(
	input wire logic i_clock, // core clock
	input wire logic i_sys_rst, // async reset, high
	input wire lutac_reg_req_s i_reg, // register access
	output logic [31:0] o_reg_rdata, // read data
	output logic o_reg_rvalid, // read data valid
	output logic o_tbl_req, // table access outstanding
	output lutac_tbl_cmd_s o_tbl, // table access
	input wire lutac_tbl_rsp_s i_tbl_rsp // table answer
);
	localparam logic [11:0] LAST_ADDR = 12'(LOOKUP_DEPTH - 1);

	if (LOOKUP_DEPTH < 2 || LOOKUP_DEPTH > 4096)
	begin : g_bad_depth
		$error("LOOKUP_DEPTH must lie in 2..4096");
	end

	lutac_main_s q;
	lutac_main_s d;
	logic start;
	lutac_tbl_cmd_s cmd;
	logic port_done;
	logic port_hit;
	logic [3:0][31:0] port_rdata;
	logic wr_hit_lk;
	logic wr_hit_st;
	logic rd_clear;
	logic either;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[8*i +: 8] = wdata[8*i +: 8];
		end
		return res;
	endfunction

	function automatic logic hit(input lutac_reg_req_s req, input logic [15:0] off);
		return req.addr[15:2] == off[15:2];
	endfunction

	lutac_tbl_port i_lutac_tbl_port (
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_start(start),
		.i_cmd(cmd),
		.i_rsp(i_tbl_rsp),
		.o_req(o_tbl_req),
		.o_cmd(o_tbl),
		.o_done(port_done),
		.o_hit(port_hit),
		.o_rdata(port_rdata)
	);

	always_comb
	begin
		logic [31:0] w;
		w = RST_WORD;
		d = q;
		start = 1'b0;
		cmd = '0;
		either = q.lk_ready | (q.srch_seen & ~q.lk_go);
		wr_hit_lk = i_reg.wr && hit(i_reg, OFF_LOOKUP_CTRL) && !q.lk_go;
		wr_hit_st = i_reg.wr && hit(i_reg, OFF_STATIC_CTRL) && !q.st_go;
		rd_clear = i_reg.rd && hit(i_reg, OFF_ENTRY4) && i_reg.be[CLEAR_LANE];

		// software side of index and entry
		if (i_reg.wr && hit(i_reg, OFF_INDEX0))
			d.idx0 = merge(q.idx0, i_reg.wdata, i_reg.be) & INDEX0_WMASK;
		if (i_reg.wr && hit(i_reg, OFF_INDEX1))
			d.idx1 = merge(q.idx1, i_reg.wdata, i_reg.be);
		for (int i = 0; i < 4; i++)
		begin
			if (i_reg.wr && hit(i_reg, OFF_ENTRY1 + 16'(4 * i)))
				d.entry[i] = merge(q.entry[i], i_reg.wdata, i_reg.be);
		end
		if (wr_hit_lk)
		begin
			w = merge({24'h0, q.lk_go, 2'h0, q.lk_res, q.lk_direct, q.lk_act}, i_reg.wdata, i_reg.be);
			d.lk_go = w[GO_BIT];
			d.lk_res = w[RES_LSB +: 2];
			d.lk_direct = w[DIRECT_BIT];
			d.lk_act = lutac_action_e'(w[ACT_LSB +: 2]);
		end
		if (wr_hit_st)
		begin
			w = merge({10'h0, q.st_idx, 8'h0, q.st_go, q.st_res, q.st_sel, q.st_read}, i_reg.wdata, i_reg.be);
			d.st_go = w[GO_BIT];
			d.st_idx = w[SIDX_LSB +: 6];
			d.st_res = w[SRES_LSB +: 5];
			d.st_sel = w[SEL_BIT];
			d.st_read = w[SOP_BIT];
		end
		if (rd_clear)
			d.lk_ready = 1'b0;

		unique case (q.fsm)
			FSM_IDLE:
			begin
				if (q.lk_go)
				begin
					unique case (q.lk_act)
						ACT_NOP:
							d.lk_go = 1'b0;
						ACT_WRITE, ACT_READ:
						begin
							start = 1'b1;
							cmd.sel = TBL_LOOKUP;
							cmd.write = q.lk_act == ACT_WRITE;
							cmd.direct = q.lk_direct;
							cmd.addr = q.lk_direct ? q.idx1[11:0] : RST_ADDR;
							cmd.filter_group_id = q.idx0[FID_LSB +: 7];
							cmd.mac = {q.idx0[15:0], q.idx1};
							cmd.wdata = q.entry;
							d.srch_seen = 1'b0;
							d.fsm = FSM_LK;
						end
						ACT_SEARCH:
						begin
							d.lk_count = RST_COUNT;
							d.scan = RST_ADDR;
							d.srch_seen = 1'b1;
							d.lk_ready = 1'b0;
							d.fsm = FSM_SCAN;
						end
					endcase
				end
				else if (q.st_go)
				begin
					start = 1'b1;
					cmd.sel = q.st_sel ? TBL_RMC : TBL_STATIC;
					cmd.write = !q.st_read;
					cmd.direct = 1'b1;
					cmd.addr = q.st_sel ? {6'h0, q.st_idx} : {8'h0, q.st_idx[3:0]};
					cmd.wdata = q.st_sel ? {64'h0, q.entry[1], 32'h0} : q.entry;
					d.fsm = FSM_ST;
				end
			end
			FSM_LK:
			begin
				if (port_done)
				begin
					if (o_tbl.write == 1'b0)
						d.entry = port_rdata;
					d.lk_go = 1'b0;
					d.fsm = FSM_IDLE;
				end
			end
			FSM_SCAN:
			begin
				if (!o_tbl_req && !port_done)
				begin
					start = 1'b1;
					cmd.sel = TBL_LOOKUP;
					cmd.direct = 1'b1;
					cmd.addr = q.scan;
				end
				if (port_done)
				begin
					if (port_hit)
					begin
						d.entry = port_rdata;
						d.lk_count = q.lk_count + 14'h1;
						d.lk_ready = 1'b1;
						d.fsm = FSM_HOLD;
					end
					else if (q.scan == LAST_ADDR)
					begin
						d.lk_go = 1'b0;
						d.fsm = FSM_IDLE;
					end
					else
						d.scan = q.scan + 12'h1;
				end
			end
			FSM_HOLD:
			begin
				if (rd_clear)
				begin
					if (q.scan == LAST_ADDR)
					begin
						d.lk_go = 1'b0;
						d.fsm = FSM_IDLE;
					end
					else
					begin
						d.scan = q.scan + 12'h1;
						d.fsm = FSM_SCAN;
					end
				end
			end
			FSM_ST:
			begin
				if (port_done)
				begin
					if (o_tbl.write == 1'b0)
					begin
						// only word two on reserved multicast
						if (o_tbl.sel == TBL_RMC)
							d.entry[1] = port_rdata[1];
						else
							d.entry = port_rdata;
					end
					d.st_go = 1'b0;
					d.fsm = FSM_IDLE;
				end
			end
		endcase

		d.rvalid = i_reg.rd;
		d.rdata = RST_WORD;
		if (i_reg.rd)
		begin
			if (hit(i_reg, OFF_INDEX0))
				d.rdata = q.idx0;
			else if (hit(i_reg, OFF_INDEX1))
				d.rdata = q.idx1;
			else if (hit(i_reg, OFF_LOOKUP_CTRL))
				d.rdata = {2'h0, q.lk_count, 8'h0, q.lk_go, q.lk_ready, either, q.lk_res, q.lk_direct, q.lk_act};
			else if (hit(i_reg, OFF_STATIC_CTRL))
				d.rdata = {10'h0, q.st_idx, 8'h0, q.st_go, q.st_res, q.st_sel, q.st_read};
			else if (i_reg.addr[15:4] == OFF_ENTRY1[15:4])
				d.rdata = q.entry[i_reg.addr[3:2]];
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			q <= '0;
			q.fsm <= FSM_IDLE;
		end
		else
			q <= d;
	end

	assign o_reg_rdata = q.rdata;
	assign o_reg_rvalid = q.rvalid;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);

	a_write_decode: assert property (start && q.fsm == FSM_IDLE && q.lk_go |-> ##1 o_tbl.write == (q.lk_act == ACT_WRITE) || o_tbl.sel != TBL_LOOKUP) else $error("lookup op decode wrong");
	a_go_selfclear: assert property (q.fsm == FSM_LK && port_done |=> !q.lk_go && q.fsm == FSM_IDLE) else $error("lookup go not cleared");
	a_count_step: assert property (q.fsm == FSM_SCAN && port_done && port_hit |=> q.lk_count == $past(q.lk_count) + 14'h1 && q.lk_ready) else $error("count or ready wrong");
	a_ready_clear: assert property (q.fsm == FSM_HOLD && rd_clear |=> !q.lk_ready) else $error("ready not cleared");
	a_either_read: assert property (i_reg.rd && hit(i_reg, OFF_LOOKUP_CTRL) |=> o_reg_rvalid && o_reg_rdata[EITHER_BIT] == ($past(q.lk_ready) | ($past(q.srch_seen) & ~$past(q.lk_go)))) else $error("combined bit wrong");
	a_direct_addr: assert property (o_tbl_req && o_tbl.sel == TBL_LOOKUP && q.fsm == FSM_LK && o_tbl.direct |-> o_tbl.addr == q.idx1[11:0]) else $error("direct address wrong");
	a_static_index: assert property (o_tbl_req && o_tbl.sel == TBL_STATIC |-> o_tbl.addr == {8'h0, q.st_idx[3:0]}) else $error("static index wrong");
	a_rmc_word: assert property (q.fsm == FSM_ST && port_done && o_tbl.sel == TBL_RMC |=> q.entry[0] == $past(q.entry[0]) && q.entry[3] == $past(q.entry[3])) else $error("rmc touched other words");
	a_search_end: assert property (q.fsm == FSM_SCAN && port_done && !port_hit && q.scan == LAST_ADDR |=> !q.lk_go && !o_tbl_req && q.fsm == FSM_IDLE) else $error("search did not end");
	a_static_done: assert property (q.fsm == FSM_ST && port_done |=> !q.st_go) else $error("static go not cleared");

	c_search_hit: cover property (q.fsm == FSM_HOLD ##[1:50] rd_clear);
	c_static_write: cover property (q.fsm == FSM_ST && port_done && o_tbl.write);
	c_rmc_read: cover property (q.fsm == FSM_ST && port_done && o_tbl.sel == TBL_RMC && !o_tbl.write);
	c_lookup_read: cover property (q.fsm == FSM_LK && port_done && !o_tbl.write);
endmodule
`default_nettype wire

/* File: bench/lutac_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module lutac_top_tb
	import lutac_pkg::*;
;
	localparam int DEPTH = 8;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	lutac_reg_req_s i_reg = '0;
	lutac_tbl_rsp_s i_tbl_rsp = '0;
	logic [31:0] o_reg_rdata;
	logic o_reg_rvalid;
	logic o_tbl_req;
	lutac_tbl_cmd_s o_tbl;
	int error_cnt = 0;
	int total_checks = 0;
	int scan_n = 0;
	logic [15:0] lf = 16'd16834;
	logic [63:0] expq[$];
	logic [63:0] em;
	logic [31:0] last_rd;
	logic [31:0] d0, d1, v;
	logic [3:0][31:0] tbl_w, ew;
	logic [7:0] hit_map = 8'h24;
	logic srch = 1'b0;
	lutac_tbl_cmd_s cmd_q, ec;
	logic [31:0] ctl[4] = '{32'h002a_0080, 32'h002a_0082, 32'h002a_0083, 32'h0025_0081};

	always #10 i_clock = ~i_clock;

	lutac_top #(.LOOKUP_DEPTH(DEPTH)) i_lutac_top (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg(i_reg),
		.o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_tbl_req(o_tbl_req), .o_tbl(o_tbl),
		.i_tbl_rsp(i_tbl_rsp));

	function automatic logic [31:0] rnd();
		logic [31:0] r;
		for (int k = 0; k < 32; k++)
		begin
			lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
			r[k] = lf[0];
		end
		return r;
	endfunction

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string nm, input logic [127:0] e, input logic [127:0] g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge i_clock);
		i_reg <= '{wr: 1'b1, rd: 1'b0, addr: a, be: 4'hf, wdata: d};
		@(negedge i_clock);
		i_reg.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
		@(negedge i_clock);
		expq.push_back({e, m});
		i_reg <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0};
		@(negedge i_clock);
		i_reg.rd <= 1'b0;
		@(negedge i_clock);
		#1;
	endtask

	task automatic poll(input logic [15:0] a, input int b, input logic val);
		for (int n = 0; n < 60; n++)
		begin
			rd(a, 32'h0, 32'h0);
			if (last_rd[b] === val)
				return;
		end
		check("poll limit", 128'h0, 128'h1);
	endtask

	task automatic cchk(input logic key);
		check("cmd head", {ec.sel, ec.write, ec.direct, ec.addr}, {cmd_q.sel, cmd_q.write, cmd_q.direct, cmd_q.addr});
		if (ec.write)
			check("cmd data", ec.wdata, cmd_q.wdata);
		if (key)
			check("cmd key", {ec.filter_group_id, ec.mac}, {cmd_q.filter_group_id, cmd_q.mac});
	endtask

	// read results come off the queue of notes
	always @(negedge i_clock)
		if (o_reg_rvalid === 1'b1)
		begin
			last_rd = o_reg_rdata;
			if (expq.size() == 0)
				check("stray read", 128'h0, 128'h1);
			else
			begin
				em = expq.pop_front();
				if (em[31:0] != 32'h0)
					check("reg read", 128'(em[63:32] & em[31:0]), 128'(o_reg_rdata & em[31:0]));
			end
		end

	// table stand-in, one answer per access
	always @(negedge i_clock)
	begin
		i_tbl_rsp.ack <= o_tbl_req === 1'b1 && !i_tbl_rsp.ack;
		if (o_tbl_req === 1'b1 && !i_tbl_rsp.ack)
		begin
			cmd_q <= o_tbl;
			i_tbl_rsp.hit <= srch && hit_map[o_tbl.addr[2:0]];
			i_tbl_rsp.rdata <= srch ? {tbl_w[3:1], tbl_w[0] ^ 32'(o_tbl.addr)} : tbl_w;
			if (srch)
			begin
				check("scan addr", 128'(scan_n), 128'(o_tbl.addr));
				scan_n++;
			end
		end
	end

	initial
	begin
		#400us;
		error_cnt++;
		end_sim();
	end

	initial
	begin
		tbl_w = {rnd(), rnd(), rnd(), rnd()};
		ew = {rnd(), rnd(), rnd(), rnd()};
		d0 = rnd();
		d1 = rnd();
		repeat (16) @(negedge i_clock);
		i_sys_rst = 1'b0;
		rd(OFF_LOOKUP_CTRL, 32'h0, 32'hffff_ffff);
		rd(OFF_STATIC_CTRL, 32'h0, 32'hffff_ffff);
		rd(16'h0500, 32'h0, 32'hffff_ffff);
		wr(OFF_INDEX0, d0);
		wr(OFF_INDEX1, d1);
		rd(OFF_INDEX0, d0 & INDEX0_WMASK, 32'hffff_ffff);
		rd(OFF_INDEX1, d1, 32'hffff_ffff);
		for (int k = 0; k < 4; k++)
			wr(OFF_ENTRY1 + 16'(4 * k), ew[k]);
		// hashed write
		wr(OFF_LOOKUP_CTRL, 32'h0000_0081);
		poll(OFF_LOOKUP_CTRL, GO_BIT, 1'b0);
		rd(OFF_LOOKUP_CTRL, 32'h0000_0001, 32'hffff_ffff);
		ec = '0;
		ec.sel = TBL_LOOKUP;
		ec.write = 1'b1;
		ec.filter_group_id = d0[22:16];
		ec.mac = {d0[15:0], d1};
		ec.wdata = ew;
		cchk(1'b1);
		// direct read
		wr(OFF_LOOKUP_CTRL, 32'h0000_0086);
		poll(OFF_LOOKUP_CTRL, GO_BIT, 1'b0);
		ec.write = 1'b0;
		ec.direct = 1'b1;
		ec.addr = d1[11:0];
		cchk(1'b0);
		for (int k = 0; k < 4; k++)
			rd(OFF_ENTRY1 + 16'(4 * k), tbl_w[k], 32'hffff_ffff);
		// search with hits at 2 and 5
		srch = 1'b1;
		wr(OFF_LOOKUP_CTRL, 32'h0000_0083);
		for (int h = 0; h < 2; h++)
		begin
			poll(OFF_LOOKUP_CTRL, READY_BIT, 1'b1);
			rd(OFF_LOOKUP_CTRL, 32'h0000_00e0, 32'h0000_00e0);
			if (h == 0)
				wr(OFF_LOOKUP_CTRL, 32'h0);
			for (int k = 0; k < 4; k++)
				rd(OFF_ENTRY1 + 16'(4 * k), tbl_w[k] ^ ((k == 0) ? 32'(h ? 5 : 2) : 32'h0), 32'hffff_ffff);
			rd(OFF_LOOKUP_CTRL, 32'h0, 32'h0000_0040);
		end
		poll(OFF_LOOKUP_CTRL, GO_BIT, 1'b0);
		rd(OFF_LOOKUP_CTRL, 32'h0002_0023, 32'hffff_ffff);
		srch = 1'b0;
		check("scan count", 128'(DEPTH), 128'(scan_n));
		// static and reserved multicast accesses
		for (int s = 0; s < 4; s++)
		begin
			v = ctl[s];
			ew = {rnd(), rnd(), rnd(), rnd()};
			tbl_w = {rnd(), rnd(), rnd(), rnd()};
			for (int k = 0; k < 4; k++)
				wr(OFF_ENTRY1 + 16'(4 * k), ew[k]);
			wr(OFF_STATIC_CTRL, v);
			poll(OFF_STATIC_CTRL, GO_BIT, 1'b0);
			ec = '0;
			ec.sel = v[1] ? TBL_RMC : TBL_STATIC;
			ec.write = !v[0];
			ec.direct = 1'b1;
			ec.addr = v[1] ? 12'(v[21:16]) : 12'(v[19:16]);
			ec.wdata = v[1] ? {64'h0, ew[1], 32'h0} : ew;
			cchk(1'b0);
			for (int k = 0; k < 4; k++)
				rd(OFF_ENTRY1 + 16'(4 * k), (v[0] && (!v[1] || k == 1)) ? tbl_w[k] : ew[k], 32'hffff_ffff);
		end
		end_sim();
	end
endmodule
`default_nettype wire
